// ### common/lfa_pkg.sv
// Summary of operation
// - Lane i fault bit sets on FIFO over/underflow
// - Writing one to a lane bit clears it
// - Persisting fault sets the bit again at once
// - Summary bit clear also clears all lane bits
// - Lane fault register reads 0xFFFF after reset
// - Each trim register holds an 8-bit sampling code
// - Trims start at fuse value, readable and writable
// - Core A dual mode uses trim at 0x310
// - Core B dual mode uses trim at 0x313
// - Core A single mode with fg cal enabled: per-input trim 0x314/0x31A
// - Core B single mode with fg cal enabled: per-input trim 0x315/0x31B
// - Summary bit sets on any active lane fault
package lfa_pkg;
  localparam int          NUM_LANES = 16;
  localparam int          TRIM_W    = 8;
  localparam int          NUM_TRIM  = 6;
  localparam int          ADDR_W    = 12;
  localparam int          IDX_W     = 10;
  localparam int          DATA_W    = 32;

  // Printed offsets are word indices; byte address is four times these
  localparam logic [9:0]  IDX_ALARM_STATUS = 10'h2C1;
  localparam logic [9:0]  IDX_LANE_FAULT   = 10'h2C4;
  localparam logic [9:0]  IDX_A_DUAL       = 10'h310;
  localparam logic [9:0]  IDX_B_DUAL       = 10'h313;
  localparam logic [9:0]  IDX_A_SIN_A      = 10'h314;
  localparam logic [9:0]  IDX_B_SIN_A      = 10'h315;
  localparam logic [9:0]  IDX_A_SIN_B      = 10'h31A;
  localparam logic [9:0]  IDX_B_SIN_B      = 10'h31B;

  localparam int          SUMMARY_BIT      = 5;
  localparam logic        SUMMARY_RST      = 1'b1;
  localparam logic [15:0] LANE_FAULT_RST   = 16'hFFFF;
  localparam logic [7:0]  TRIM_RST         = 8'h00;

  localparam logic [2:0]  SLOT_A_DUAL  = 3'h0;
  localparam logic [2:0]  SLOT_B_DUAL  = 3'h1;
  localparam logic [2:0]  SLOT_A_SIN_A = 3'h2;
  localparam logic [2:0]  SLOT_B_SIN_A = 3'h3;
  localparam logic [2:0]  SLOT_A_SIN_B = 3'h4;
  localparam logic [2:0]  SLOT_B_SIN_B = 3'h5;
  localparam logic [2:0]  SLOT_NONE    = 3'h7;

  typedef enum logic [1:0] {
    LFA_LOAD_FUSE = 2'b00,
    LFA_RUN       = 2'b01
  } lfa_state_type;
endpackage

// ### common/lfa_trim_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lfa_trim_if;
  import lfa_pkg::*;
  logic [NUM_TRIM-1:0][TRIM_W-1:0] trims;
  logic                            single_mode;
  logic                            fg_cal;
  logic                            sel_in_b;
  logic [TRIM_W-1:0]               core_a_trim;
  logic [TRIM_W-1:0]               core_b_trim;

  modport ctrl (
    output trims,
    output single_mode,
    output fg_cal,
    output sel_in_b,
    input  core_a_trim,
    input  core_b_trim
  );
  modport sel (
    input  trims,
    input  single_mode,
    input  fg_cal,
    input  sel_in_b,
    output core_a_trim,
    output core_b_trim
  );
endinterface
`default_nettype wire

// ### hw/lfa_trim_sel.sv
`timescale 1ns/1ps
`default_nettype none
module lfa_trim_sel (
  input  wire logic  clock,
  input  wire logic  sys_rst,
  lfa_trim_if.sel    tif
);
  import lfa_pkg::*;

  logic [TRIM_W-1:0] a_nxt;
  logic [TRIM_W-1:0] b_nxt;
  logic [TRIM_W-1:0] a_r;
  logic [TRIM_W-1:0] b_r;

  // Unused trims never reach the delay line
  always_comb begin
    if (tif.single_mode && tif.fg_cal) begin
      a_nxt = tif.sel_in_b ? tif.trims[SLOT_A_SIN_B]
                           : tif.trims[SLOT_A_SIN_A];
      b_nxt = tif.sel_in_b ? tif.trims[SLOT_B_SIN_B]
                           : tif.trims[SLOT_B_SIN_A];
    end else begin
      a_nxt = tif.trims[SLOT_A_DUAL];
      b_nxt = tif.trims[SLOT_B_DUAL];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      a_r <= TRIM_RST;
      b_r <= TRIM_RST;
    end else begin
      a_r <= a_nxt;
      b_r <= b_nxt;
    end
  end

  assign tif.core_a_trim = a_r;
  assign tif.core_b_trim = b_r;
endmodule
`default_nettype wire

// ### hw/lfa_top.sv
`timescale 1ns/1ps
`default_nettype none
module lfa_top (
  input  wire logic                                   clock,
  input  wire logic                                   sys_rst,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [lfa_pkg::ADDR_W-1:0]             paddr,
  input  wire logic [lfa_pkg::DATA_W-1:0]             pwdata,
  output logic      [lfa_pkg::DATA_W-1:0]             prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic [lfa_pkg::NUM_LANES-1:0]          lane_overflow,
  input  wire logic [lfa_pkg::NUM_LANES-1:0]          lane_underflow,
  input  wire logic [lfa_pkg::NUM_LANES-1:0]          lane_active,
  input  wire logic [lfa_pkg::NUM_TRIM*lfa_pkg::TRIM_W-1:0] fuse_trim,
  input  wire logic                                   single_channel_mode,
  input  wire logic                                   fg_cal_enable,
  input  wire logic                                   input_sel_b,
  output logic      [lfa_pkg::TRIM_W-1:0]             core_a_trim,
  output logic      [lfa_pkg::TRIM_W-1:0]             core_b_trim,
  output logic                                        fifo_fault_summary
);
  import lfa_pkg::*;

  function automatic logic [2:0] trim_slot(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_A_DUAL:  trim_slot = SLOT_A_DUAL;
      IDX_B_DUAL:  trim_slot = SLOT_B_DUAL;
      IDX_A_SIN_A: trim_slot = SLOT_A_SIN_A;
      IDX_B_SIN_A: trim_slot = SLOT_B_SIN_A;
      IDX_A_SIN_B: trim_slot = SLOT_A_SIN_B;
      IDX_B_SIN_B: trim_slot = SLOT_B_SIN_B;
      default:     trim_slot = SLOT_NONE;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[ADDR_W-1:2];
    is_mapped = (a[1:0] == 2'h0) &&
                ((idx == IDX_ALARM_STATUS) || (idx == IDX_LANE_FAULT) ||
                 (trim_slot(idx) != SLOT_NONE));
  endfunction

  lfa_trim_if tif ();

  lfa_state_type                   state_r;
  lfa_state_type                   state_nxt;
  logic [NUM_LANES-1:0]            fault_r;
  logic [NUM_LANES-1:0]            fault_nxt;
  logic                            summary_r;
  logic                            summary_nxt;
  logic [NUM_TRIM-1:0][TRIM_W-1:0] trim_r;
  logic [NUM_TRIM-1:0][TRIM_W-1:0] trim_nxt;
  logic [DATA_W-1:0]               prdata_r;
  logic [DATA_W-1:0]               prdata_nxt;
  logic                            err_r;
  logic                            err_nxt;

  logic [IDX_W-1:0]                idx;
  logic [2:0]                      slot;
  logic                            setup;
  logic                            wr_take;
  logic                            wr_lane;
  logic                            clr_all;
  logic [NUM_LANES-1:0]            lane_evt;
  logic                            any_active_evt;

  // Zero-wait slave; every access completes in its first access cycle
  assign pready   = 1'b1;
  assign idx      = paddr[ADDR_W-1:2];
  assign slot     = trim_slot(idx);
  assign setup    = psel && !penable;
  assign wr_take  = psel && penable && pwrite && is_mapped(paddr);
  assign wr_lane  = wr_take && (idx == IDX_LANE_FAULT);
  assign clr_all  = wr_take && (idx == IDX_ALARM_STATUS) &&
                    pwdata[SUMMARY_BIT];
  assign lane_evt = lane_overflow | lane_underflow;
  assign any_active_evt = |(lane_evt & lane_active);

  // Set wins over clear so a persisting fault is never lost
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++) begin : g_lane
      assign fault_nxt[g] = (fault_r[g] & ~((wr_lane & pwdata[g]) | clr_all))
                            | lane_evt[g];
    end
    for (g = 0; g < NUM_TRIM; g++) begin : g_trim
      assign trim_nxt[g] =
        (state_r == LFA_LOAD_FUSE) ? fuse_trim[g*TRIM_W +: TRIM_W] :
        (wr_take && (slot == 3'(g))) ? pwdata[TRIM_W-1:0] :
        trim_r[g];
    end
  endgenerate

  always_comb begin
    summary_nxt = (summary_r & ~clr_all) | any_active_evt;
    case (state_r)
      LFA_LOAD_FUSE: state_nxt = LFA_RUN;
      LFA_RUN:       state_nxt = LFA_RUN;
      default:       state_nxt = LFA_LOAD_FUSE;
    endcase
  end

  // Read data is captured in setup so it is stable for the access cycle
  always_comb begin
    prdata_nxt = prdata_r;
    err_nxt    = err_r;
    if (setup) begin
      prdata_nxt = '0;
      err_nxt    = !is_mapped(paddr);
      if (is_mapped(paddr)) begin
        if (idx == IDX_ALARM_STATUS) begin
          prdata_nxt[SUMMARY_BIT] = summary_r;
        end else if (idx == IDX_LANE_FAULT) begin
          prdata_nxt[NUM_LANES-1:0] = fault_r;
        end else begin
          prdata_nxt[TRIM_W-1:0] = trim_r[slot];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r   <= LFA_LOAD_FUSE;
      fault_r   <= LANE_FAULT_RST;
      summary_r <= SUMMARY_RST;
      trim_r    <= {NUM_TRIM{TRIM_RST}};
      prdata_r  <= '0;
      err_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      fault_r   <= fault_nxt;
      summary_r <= summary_nxt;
      trim_r    <= trim_nxt;
      prdata_r  <= prdata_nxt;
      err_r     <= err_nxt;
    end
  end

  assign tif.trims       = trim_r;
  assign tif.single_mode = single_channel_mode;
  assign tif.fg_cal      = fg_cal_enable;
  assign tif.sel_in_b    = input_sel_b;

  lfa_trim_sel u_sel (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tif     (tif)
  );

  assign prdata             = prdata_r;
  assign pslverr            = err_r && psel && penable;
  assign core_a_trim        = tif.core_a_trim;
  assign core_b_trim        = tif.core_b_trim;
  assign fifo_fault_summary = summary_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_lane_clear_wr;
    psel && penable && pwrite && (paddr == ADDR_W'({IDX_LANE_FAULT, 2'b00}));
  endsequence

  sequence s_summary_clear_wr;
    psel && penable && pwrite && pwdata[SUMMARY_BIT] &&
    (paddr == ADDR_W'({IDX_ALARM_STATUS, 2'b00}));
  endsequence

  sequence s_trim_wr_a_dual;
    psel && penable && pwrite && (state_r == LFA_RUN) &&
    (paddr == ADDR_W'({IDX_A_DUAL, 2'b00}));
  endsequence

  a_lane_fault_set: assert property (
    (|lane_evt) |=> ((fault_r & $past(lane_evt)) == $past(lane_evt)))
    else $error("lane fault bit not set by event");

  a_lane_w1c_clear: assert property (
    (s_lane_clear_wr and ##0 (lane_evt == '0)) |=>
      ((fault_r & $past(pwdata[NUM_LANES-1:0])) == '0))
    else $error("lane fault bit not cleared by write one");

  // A fresh event on an unwritten lane may legally set it
  a_lane_w1c_keep: assert property (
    (s_lane_clear_wr and ##0 (lane_evt == '0)) |=>
      ((fault_r & ~$past(pwdata[NUM_LANES-1:0])) ==
       ($past(fault_r) & ~$past(pwdata[NUM_LANES-1:0]))))
    else $error("lane fault write zero changed a bit");

  a_summary_clr_all: assert property (
    (s_summary_clear_wr and ##0 (lane_evt == '0)) |=>
      (fault_r == '0) && !summary_r)
    else $error("summary clear did not clear lane faults");

  a_reset_all_set: assert property (
    $fell(sys_rst) |-> (fault_r == LANE_FAULT_RST) && summary_r)
    else $error("fault flags not all set after reset");

  a_fuse_load_trim: assert property (
    (state_r == LFA_LOAD_FUSE) |=>
      (trim_r == $past(fuse_trim)) && (state_r == LFA_RUN))
    else $error("fuse trims not loaded after reset");

  a_trim_write_back: assert property (
    s_trim_wr_a_dual |=> (trim_r[SLOT_A_DUAL] == $past(pwdata[TRIM_W-1:0])))
    else $error("trim write not stored");

  a_trim_read_back: assert property (
    (setup && !pwrite && (paddr == ADDR_W'({IDX_B_SIN_B, 2'b00}))) |=>
      (prdata == {{(DATA_W-TRIM_W){1'b0}}, $past(trim_r[SLOT_B_SIN_B])}))
    else $error("trim read data wrong");

  a_dual_route: assert property (
    !(single_channel_mode && fg_cal_enable) |=>
      (core_a_trim == $past(trim_r[SLOT_A_DUAL])) &&
      (core_b_trim == $past(trim_r[SLOT_B_DUAL])))
    else $error("dual mode trim routing wrong");

  a_single_route: assert property (
    (single_channel_mode && fg_cal_enable) |=>
      (core_a_trim == ($past(input_sel_b) ? $past(trim_r[SLOT_A_SIN_B])
                                          : $past(trim_r[SLOT_A_SIN_A]))) &&
      (core_b_trim == ($past(input_sel_b) ? $past(trim_r[SLOT_B_SIN_B])
                                          : $past(trim_r[SLOT_B_SIN_A]))))
    else $error("single mode trim routing wrong");

  a_summary_set: assert property (
    any_active_evt |=> summary_r [*1] ##0 (fifo_fault_summary == 1'b1))
    else $error("summary alarm not set by active lane fault");

  a_unmapped_err: assert property (
    (setup && !is_mapped(paddr)) |=> (penable -> pslverr))
    else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// ### bench/lfa_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lfa_pkg::*;
  logic                       clock;
  logic                       sys_rst;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [ADDR_W-1:0]          paddr;
  logic [DATA_W-1:0]          pwdata;
  logic [DATA_W-1:0]          prdata;
  logic                       pready;
  logic                       pslverr;
  logic [NUM_LANES-1:0]       lane_overflow;
  logic [NUM_LANES-1:0]       lane_underflow;
  logic [NUM_LANES-1:0]       lane_active;
  logic [NUM_TRIM*TRIM_W-1:0] fuse_trim;
  logic                       single_channel_mode;
  logic                       fg_cal_enable;
  logic                       input_sel_b;
  logic [TRIM_W-1:0]          core_a_trim;
  logic [TRIM_W-1:0]          core_b_trim;
  logic                       fifo_fault_summary;
  int                         fail_count;
  int                         samples_checked;
  int                         sel;
  logic [DATA_W-1:0]          rd;
  logic                       err;
  logic [ADDR_W-1:0]          lane;
  logic [ADDR_W-1:0]          stat;
  logic [ADDR_W-1:0]          trim_addr [NUM_TRIM];

  lfa_top lfa_top_i (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lane_overflow(lane_overflow),
    .lane_underflow(lane_underflow), .lane_active(lane_active),
    .fuse_trim(fuse_trim), .single_channel_mode(single_channel_mode),
    .fg_cal_enable(fg_cal_enable), .input_sel_b(input_sel_b),
    .core_a_trim(core_a_trim), .core_b_trim(core_b_trim),
    .fifo_fault_summary(fifo_fault_summary)
  );

  function automatic logic [ADDR_W-1:0] ba(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Holds the request until pready is seen; idle edge after release
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        complete_run();
      end
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                       input string what);
    apb(a, 1'b0, 32'h0);
    check(rd, exp, what);
  endtask

  // One-cycle event pulse, like a single FIFO slip
  task automatic pulse(input logic [15:0] ov, input logic [15:0] un);
    lane_overflow  <= ov;
    lane_underflow <= un;
    @(posedge clock);
    lane_overflow  <= 16'h0000;
    lane_underflow <= 16'h0000;
    repeat (2) @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    repeat (3000) @(posedge clock);
    fail_count++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    lane_overflow = '0;
    lane_underflow = '0;
    lane_active = 16'h00FF;
    fuse_trim = 48'h151413121110;
    single_channel_mode = 1'b0;
    fg_cal_enable = 1'b0;
    input_sel_b = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    lane = ba(IDX_LANE_FAULT);
    stat = ba(IDX_ALARM_STATUS);
    trim_addr = '{ba(IDX_A_DUAL), ba(IDX_B_DUAL), ba(IDX_A_SIN_A),
                  ba(IDX_B_SIN_A), ba(IDX_A_SIN_B), ba(IDX_B_SIN_B)};
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    // Fuse load lands one edge after release
    repeat (2) @(posedge clock);
    rdchk(lane, 32'h0000FFFF, "lane reset");
    check({31'h0, err}, 32'h0, "mapped err");
    rdchk(stat, 32'h20, "summary reset");
    for (int k = 0; k < NUM_TRIM; k++) begin
      rdchk(trim_addr[k], 32'h10 + k, "fuse trim");
    end
    wr(stat, 32'h20);
    rdchk(lane, 32'h0, "lane all clear");
    rdchk(stat, 32'h0, "summary clear");
    pulse(16'h0000, 16'h0200);
    rdchk(lane, 32'h0200, "underflow flag");
    check({31'h0, fifo_fault_summary}, 32'h0, "inactive summary");
    pulse(16'h0004, 16'h0000);
    rdchk(lane, 32'h0204, "overflow flag");
    rdchk(stat, 32'h20, "summary set");
    check({31'h0, fifo_fault_summary}, 32'h1, "summary pin");
    // Only the summary bit clears the lanes; other alarm bits must not
    wr(stat, 32'h0000001F);
    rdchk(lane, 32'h0204, "no summary clear");
    rdchk(stat, 32'h20, "summary kept");
    // Bit 3 still faulting while cleared, must trip again
    lane_overflow <= 16'h0008;
    wr(lane, 32'h0000000C);
    rdchk(lane, 32'h0208, "persist rearm");
    lane_overflow <= 16'h0000;
    wr(lane, 32'h00000208);
    rdchk(lane, 32'h0, "w1c clear");
    for (int k = 0; k < NUM_TRIM; k++) begin
      wr(trim_addr[k], 32'hFFFFFFC0 + k);
      rdchk(trim_addr[k], 32'hC0 + k, "trim rw");
    end
    wr(ADDR_W'(trim_addr[0] + 1), 32'h55);
    check({31'h0, err}, 32'h1, "misaligned err");
    rdchk(trim_addr[0], 32'hC0, "misaligned ignored");
    apb(12'h004, 1'b0, 32'h0);
    check(rd, 32'h0, "unmapped data");
    check({31'h0, err}, 32'h1, "unmapped err");
    for (int m = 0; m < 8; m++) begin
      {single_channel_mode, fg_cal_enable, input_sel_b} <= m[2:0];
      repeat (3) @(posedge clock);
      sel = (m[2] & m[1]) ? (m[0] ? 4 : 2) : 0;
      check({24'h0, core_a_trim}, 32'hC0 + sel, "core a");
      check({24'h0, core_b_trim}, 32'hC1 + sel, "core b");
    end
    // Mid-run reset must restore the flags and reload the fuse trims
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    rdchk(lane, 32'h0000FFFF, "lane re-reset");
    rdchk(trim_addr[5], 32'h15, "fuse reload");
    complete_run();
  end
endmodule
`default_nettype wire
